//--- core/pmcc_ctrl.sv
// Functional notes
// - Fast mode is CPU on fast oscillator, slow mode on slow oscillator.
// - Writing one to nap_request enters idle mode.
// - Idle mode keeps either fast or slow clock as system source.
// - Idle stops the CPU clock, peripherals keep running.
// - gate_peripherals_in_nap stops timer0-2, UART, ADC clocks in idle.
// - Idle ends on reset or any enabled interrupt.
// - deep_sleep_request with halt_low_osc_in_deep_sleep zero enters halt.
// - Halt stops all clocks except the slow oscillator and an enabled timer3 and watchdog.
// - Halt ends on reset, pin wake-up or timer3 interrupt.
// - deep_sleep_request with halt_low_osc_in_deep_sleep one enters stop.
// - Stop stops every clock except an enabled watchdog.
// - Stop ends only on reset or pin wake-up.
// - No halt or stop entry while an enabled external line is low.
// - Any enabled interrupt wakes idle; pins or timer3 wake halt; only pins wake stop.
// - gate_high_osc stops fast oscillator; changes accepted only in slow mode.
// - sysclk_source_sel picks slow or fast; changes only with gate off.
// - sysclk_divider codes 00,01,10,11 divide by 16,4,2,1.
// - A new divider value takes effect within 16 cycles.
// - Writes giving an invalid clock_setup_reg combination are rejected.
// - Enabled external line wakes halt or stop regardless of global enable.
//
// Chosen here: register access over Avalon-MM.
module pmcc_ctrl (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_b,
    // Avalon-MM slave, word addressed.
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Wake sources.
    input wire logic [2:0] ext_line_pin,
    input wire logic port_wake,
    input wire logic irq_pending,
    input wire logic tmr3_irq,
    input wire logic tmr3_enable,
    // Clock control outputs.
    output pmcc_pkg::pmcc_gates_type gates,
    output logic sysclk_source_sel,
    output logic sysclk_tick,
    output pmcc_pkg::pmcc_mode_type mode
);

    // ****************************************************
    // State.
    // ****************************************************
    typedef struct packed {
        pmcc_pkg::pmcc_mode_type mode;
        logic [7:0] power_mode;
        logic [5:0] clock_setup;
        logic [7:0] aux_two;
        logic [2:0] wake_en;
        logic [1:0] div_act;
        logic [3:0] div_cnt;
        logic tick;
        logic wait_b;
        logic [31:0] rdata;
        pmcc_pkg::pmcc_gates_type gates;
    } pmcc_regs_type;

    pmcc_regs_type s_r;
    pmcc_regs_type s_nxt;
    logic wr_acc;
    logic rd_req;
    logic pin_wake;
    logic entry_block;
    logic slow_run;
    logic [5:0] cs_w;
    logic [3:0] div_last;
    logic wdt_on;

    // Divider terminal count for a prescaler code.
    function automatic logic [3:0] pmcc_div_last(input logic [1:0] code);
        case (code)
            2'b00: pmcc_div_last = 4'hf;
            2'b01: pmcc_div_last = 4'h3;
            2'b10: pmcc_div_last = 4'h1;
            default: pmcc_div_last = 4'h0;
        endcase
    endfunction

    // ****************************************************
    // Decoded conditions.
    // ****************************************************
    // A low external line with its enable set is a pin wake, whatever
    // the global interrupt enable says.
    assign pin_wake = (|(~ext_line_pin & s_r.wake_en)) | port_wake;
    assign entry_block = |(~ext_line_pin & s_r.wake_en);
    assign slow_run = (s_r.mode == pmcc_pkg::MODE_RUN) &&
        !s_r.clock_setup[pmcc_pkg::POS_SRC_SEL];
    assign wr_acc = write && !read && !s_r.wait_b && byteenable[0];
    assign rd_req = read && !write;
    assign div_last = pmcc_div_last(s_r.div_act);

    // ****************************************************
    // Next state.
    // ****************************************************
    always_comb begin
        s_nxt = s_r;
        cs_w = s_r.clock_setup;
        wdt_on = 1'b0;
        s_nxt.tick = 1'b0;

        // Bus handshake: one wait cycle, then the answer edge.
        s_nxt.wait_b = !((read || write) && s_r.wait_b);
        if (rd_req && s_r.wait_b) begin
            case (address)
                pmcc_pkg::IDX_POWER_MODE: s_nxt.rdata = {24'h0, s_r.power_mode};
                pmcc_pkg::IDX_CLOCK_SETUP: s_nxt.rdata = {26'h0, s_r.clock_setup};
                pmcc_pkg::IDX_AUX_TWO: s_nxt.rdata = {24'h0, s_r.aux_two};
                pmcc_pkg::IDX_WAKE_CTRL: s_nxt.rdata = {29'h0, s_r.wake_en};
                pmcc_pkg::IDX_MODE_STATUS: s_nxt.rdata = {24'h0, s_r.mode,
                    s_r.div_act, s_r.gates.fast_osc, s_r.gates.slow_osc,
                    entry_block, pin_wake};
                default: s_nxt.rdata = 32'h0;
            endcase
        end

        // Register writes.
        if (wr_acc) begin
            case (address)
                pmcc_pkg::IDX_POWER_MODE: begin
                    s_nxt.power_mode = writedata[7:0] & pmcc_pkg::MASK_POWER_MODE;
                end
                pmcc_pkg::IDX_CLOCK_SETUP: begin
                    cs_w[5:4] = writedata[5:4];
                    cs_w[1:0] = writedata[1:0];
                    // Fast oscillator gate moves only in slow run mode.
                    if (slow_run) begin
                        cs_w[pmcc_pkg::POS_GATE_HIGH] =
                            writedata[pmcc_pkg::POS_GATE_HIGH];
                    end
                    // Source moves only with the fast oscillator running,
                    // and never into fast source with the gate set.
                    if (!s_r.clock_setup[pmcc_pkg::POS_GATE_HIGH] &&
                        !cs_w[pmcc_pkg::POS_GATE_HIGH]) begin
                        cs_w[pmcc_pkg::POS_SRC_SEL] =
                            writedata[pmcc_pkg::POS_SRC_SEL];
                    end
                    s_nxt.clock_setup = cs_w;
                end
                pmcc_pkg::IDX_AUX_TWO: s_nxt.aux_two = writedata[7:0];
                pmcc_pkg::IDX_WAKE_CTRL: s_nxt.wake_en = writedata[2:0];
                default: begin
                end
            endcase
        end

        // Mode sequencing.
        case (s_r.mode)
            pmcc_pkg::MODE_RUN: begin
                if (s_r.power_mode[pmcc_pkg::POS_DEEP]) begin
                    if (entry_block) begin
                        // Refused entry drops the request so the CPU
                        // carries on instead of sleeping later.
                        s_nxt.power_mode[pmcc_pkg::POS_DEEP] = 1'b0;
                    end else if (s_r.clock_setup[pmcc_pkg::POS_HALT_LOW_OSC]) begin
                        s_nxt.mode = pmcc_pkg::MODE_STOP;
                    end else begin
                        s_nxt.mode = pmcc_pkg::MODE_HALT;
                    end
                end else if (s_r.power_mode[pmcc_pkg::POS_NAP]) begin
                    s_nxt.mode = pmcc_pkg::MODE_NAP;
                end
            end
            pmcc_pkg::MODE_NAP: begin
                if (irq_pending || pin_wake) begin
                    s_nxt.mode = pmcc_pkg::MODE_RUN;
                    s_nxt.power_mode[pmcc_pkg::POS_NAP] = 1'b0;
                end
            end
            pmcc_pkg::MODE_HALT: begin
                if (pin_wake || tmr3_irq) begin
                    s_nxt.mode = pmcc_pkg::MODE_RUN;
                    s_nxt.power_mode[pmcc_pkg::POS_DEEP] = 1'b0;
                end
            end
            pmcc_pkg::MODE_STOP: begin
                if (pin_wake) begin
                    s_nxt.mode = pmcc_pkg::MODE_RUN;
                    s_nxt.power_mode[pmcc_pkg::POS_DEEP] = 1'b0;
                end
            end
            default: s_nxt.mode = pmcc_pkg::MODE_RUN;
        endcase

        // Watchdog clock: 0x never, 10 only in run, 11 always.
        case (s_r.aux_two[7:6])
            2'b10: wdt_on = (s_nxt.mode == pmcc_pkg::MODE_RUN);
            2'b11: wdt_on = 1'b1;
            default: wdt_on = 1'b0;
        endcase

        // Clock gates follow the next mode so they switch with it.
        s_nxt.gates.cpu = (s_nxt.mode == pmcc_pkg::MODE_RUN);
        s_nxt.gates.periph = (s_nxt.mode == pmcc_pkg::MODE_RUN) ||
            ((s_nxt.mode == pmcc_pkg::MODE_NAP) &&
            !s_nxt.clock_setup[pmcc_pkg::POS_GATE_PERIPH]);
        s_nxt.gates.fast_osc = ((s_nxt.mode == pmcc_pkg::MODE_RUN) ||
            (s_nxt.mode == pmcc_pkg::MODE_NAP)) &&
            !s_nxt.clock_setup[pmcc_pkg::POS_GATE_HIGH];
        s_nxt.gates.tmr3 = (s_nxt.mode != pmcc_pkg::MODE_STOP) &&
            tmr3_enable;
        s_nxt.gates.wdt = wdt_on;
        // The slow oscillator feeds the watchdog, so stop keeps it alive
        // only for an enabled watchdog.
        s_nxt.gates.slow_osc = (s_nxt.mode != pmcc_pkg::MODE_STOP) ||
            wdt_on;

        // Prescaler: a new code is adopted only at the end of a period,
        // which keeps every tick period whole at the cost of latency.
        if (s_r.div_cnt >= div_last) begin
            s_nxt.div_cnt = 4'h0;
            s_nxt.tick = 1'b1;
            s_nxt.div_act = s_nxt.clock_setup[1:0];
        end else begin
            s_nxt.div_cnt = s_r.div_cnt + 4'h1;
        end
    end

    // ****************************************************
    // State register.
    // ****************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '{mode: pmcc_pkg::MODE_RUN,
                power_mode: pmcc_pkg::RST_POWER_MODE,
                clock_setup: pmcc_pkg::RST_CLOCK_SETUP,
                aux_two: pmcc_pkg::RST_AUX_TWO,
                wake_en: pmcc_pkg::RST_WAKE_CTRL,
                div_act: 2'b11, div_cnt: 4'h0, tick: 1'b0,
                wait_b: 1'b1, rdata: 32'h0,
                gates: '{cpu: 1'b1, fast_osc: 1'b1, slow_osc: 1'b1,
                periph: 1'b1, tmr3: 1'b0, wdt: 1'b0}};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register.
    assign readdata = s_r.rdata;
    assign waitrequest = s_r.wait_b;
    assign gates = s_r.gates;
    assign sysclk_source_sel = s_r.clock_setup[pmcc_pkg::POS_SRC_SEL];
    assign sysclk_tick = s_r.tick;
    assign mode = s_r.mode;

    // ****************************************************
    // Assertions.
    // ****************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Cycles the written divider code has waited to be adopted.
    logic [4:0] div_age_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_age_r <= 5'h0;
        end else if (s_r.clock_setup[1:0] == s_r.div_act) begin
            div_age_r <= 5'h0;
        end else begin
            div_age_r <= div_age_r + 5'h1;
        end
    end

    nap_entry_a: assert property (
        s_r.mode == pmcc_pkg::MODE_RUN && s_r.power_mode[0] &&
        !s_r.power_mode[1] |=> s_r.mode == pmcc_pkg::MODE_NAP)
        else $error("Nap request did not enter idle.");
    halt_entry_a: assert property (
        s_r.mode == pmcc_pkg::MODE_RUN && s_r.power_mode[1] &&
        !entry_block && !s_r.clock_setup[5]
        |=> s_r.mode == pmcc_pkg::MODE_HALT ##1 !s_r.gates.cpu)
        else $error("Deep sleep request did not enter halt.");
    stop_entry_a: assert property (
        s_r.mode == pmcc_pkg::MODE_RUN && s_r.power_mode[1] &&
        !entry_block && s_r.clock_setup[5]
        |=> s_r.mode == pmcc_pkg::MODE_STOP && !s_r.gates.fast_osc)
        else $error("Deep sleep request did not enter stop.");
    entry_block_a: assert property (
        s_r.mode == pmcc_pkg::MODE_RUN && entry_block
        |=> s_r.mode inside {pmcc_pkg::MODE_RUN, pmcc_pkg::MODE_NAP})
        else $error("Deep sleep entered with a low enabled line.");
    stop_hold_a: assert property (
        s_r.mode == pmcc_pkg::MODE_STOP && !pin_wake
        |=> s_r.mode == pmcc_pkg::MODE_STOP)
        else $error("Stop left without a pin wake.");
    halt_wake_a: assert property (
        s_r.mode == pmcc_pkg::MODE_HALT && tmr3_irq
        |=> s_r.mode == pmcc_pkg::MODE_RUN && s_r.gates.cpu &&
        !s_r.power_mode[1])
        else $error("Timer3 did not wake halt.");
    nap_periph_a: assert property (
        s_r.mode == pmcc_pkg::MODE_NAP && s_r.clock_setup[4]
        |-> !s_r.gates.periph && !s_r.gates.cpu)
        else $error("Peripheral clock running in gated idle.");
    gate_change_a: assert property (
        !slow_run |=> $stable(s_r.clock_setup[3]))
        else $error("Fast gate changed outside slow mode.");
    src_change_a: assert property (
        s_r.clock_setup[3] |=> $stable(s_r.clock_setup[2]))
        else $error("Source changed with fast gate set.");
    div_settle_a: assert property (
        div_age_r <= pmcc_pkg::DIV_SETTLE_CYC)
        else $error("Divider change took over sixteen cycles.");

    nap_cycle_c: cover property (
        s_r.mode == pmcc_pkg::MODE_NAP ##1 s_r.mode == pmcc_pkg::MODE_RUN);
    halt_cycle_c: cover property (
        s_r.mode == pmcc_pkg::MODE_HALT ##1 s_r.mode == pmcc_pkg::MODE_RUN);
    stop_cycle_c: cover property (
        s_r.mode == pmcc_pkg::MODE_STOP ##1 s_r.mode == pmcc_pkg::MODE_RUN);
    div_change_c: cover property (
        s_r.div_act == 2'b11 ##1 s_r.div_act == 2'b00);

endmodule // pmcc_ctrl

//--- include/pmcc_pkg.sv
package pmcc_pkg;

    // ****************************************************
    // Register map: word indexes, byte address is four times the index.
    // ****************************************************
    localparam logic [7:0] IDX_POWER_MODE = 8'h87;
    localparam logic [7:0] IDX_CLOCK_SETUP = 8'hd8;
    localparam logic [7:0] IDX_AUX_TWO = 8'hf7;
    localparam logic [7:0] IDX_WAKE_CTRL = 8'h20;
    localparam logic [7:0] IDX_MODE_STATUS = 8'h21;

    // ****************************************************
    // Reset values.
    // ****************************************************
    localparam logic [7:0] RST_POWER_MODE = 8'h00;
    localparam logic [5:0] RST_CLOCK_SETUP = 6'h23;
    localparam logic [7:0] RST_AUX_TWO = 8'h06;
    localparam logic [2:0] RST_WAKE_CTRL = 3'h0;

    // ****************************************************
    // Field positions.
    // ****************************************************
    localparam int POS_NAP = 0;
    localparam int POS_DEEP = 1;
    localparam int POS_HALT_LOW_OSC = 5;
    localparam int POS_GATE_PERIPH = 4;
    localparam int POS_GATE_HIGH = 3;
    localparam int POS_SRC_SEL = 2;
    localparam logic [7:0] MASK_POWER_MODE = 8'h8f;

    // Divider settles within this many clock cycles.
    localparam logic [4:0] DIV_SETTLE_CYC = 5'h10;

    // ****************************************************
    // Operating states.
    // ****************************************************
    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_NAP = 2'b01,
        MODE_HALT = 2'b10,
        MODE_STOP = 2'b11
    } pmcc_mode_type;

    // Clock enables that leave the block together.
    typedef struct packed {
        logic cpu;
        logic fast_osc;
        logic slow_osc;
        logic periph;
        logic tmr3;
        logic wdt;
    } pmcc_gates_type;

endpackage

//--- tb/power_mode_clock_ctrl_tb_top.sv
module power_mode_clock_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // Design ports.
    logic clk;
    logic rst_b;
    logic [7:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic waitrequest;
    logic [2:0] ext_line_pin;
    logic port_wake;
    logic irq_pending;
    logic tmr3_irq;
    logic tmr3_enable;
    pmcc_pkg::pmcc_gates_type gates;
    logic sysclk_source_sel;
    logic sysclk_tick;
    pmcc_pkg::pmcc_mode_type mode;
    // Expected read data, oldest first.
    logic [31:0] exp_q[$];
    int num_errors = 0;
    int samples_checked = 0;

    pmcc_ctrl u_pmcc_ctrl (
        .clk(clk), .rst_b(rst_b), .address(address), .read(read),
        .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .ext_line_pin(ext_line_pin), .port_wake(port_wake),
        .irq_pending(irq_pending), .tmr3_irq(tmr3_irq),
        .tmr3_enable(tmr3_enable), .gates(gates),
        .sysclk_source_sel(sysclk_source_sel), .sysclk_tick(sysclk_tick),
        .mode(mode)
    );

    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************************
    // Report, compare and bus tasks.
    // ****************************************************
    task automatic stop_test();
        $display("errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check_port(input string name, input logic [31:0] exp,
                              input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic check_rd(input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected readdata: expected %h, seen %h", exp, got);
        end
    endtask

    // The request is held until the edge that samples waitrequest low.
    task automatic bus(input logic rd_n, input logic [7:0] a,
                       input logic [7:0] d, input logic [3:0] be);
        int n;
        @(posedge clk);
        read <= rd_n;
        write <= ~rd_n;
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= be;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            $display("unexpected waitrequest: expected 0, seen %b", 1'b1);
            stop_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b0, a, d, 4'h1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(1'b1, a, 8'h00, 4'hf);
    endtask

    // Cycles from one tick to the next; the first wait aligns to a tick.
    task automatic tick_period(output int p);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (sysclk_tick !== 1'b1 && n < 40);
        p = 0;
        do begin
            @(posedge clk);
            p++;
        end while (sysclk_tick !== 1'b1 && p < 40);
        if (p >= 40) begin
            num_errors++;
            $display("unexpected sysclk_tick: expected pulse, seen none");
            stop_test();
        end
    endtask

    // Read results are matched against the oldest note when they stand.
    always @(posedge clk) begin
        if (read === 1'b1 && waitrequest === 1'b0) begin
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("unexpected readdata: expected none, seen %h",
                         readdata);
            end else begin
                check_rd(exp_q.pop_front(), readdata);
            end
        end
    end

    // ****************************************************
    // Main sequence.
    // ****************************************************
    initial begin
        int p;
        int ln;
        logic [7:0] d;
        int divs[4] = '{16, 4, 2, 1};
        rst_b = 1'b0;
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        byteenable = 4'h0;
        writedata = 32'h0;
        ext_line_pin = 3'h7;
        port_wake = 1'b0;
        irq_pending = 1'b0;
        tmr3_irq = 1'b0;
        tmr3_enable = 1'b0;
        void'($urandom(26));
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        // Reset values, storage bits, a masked write and an unmapped place.
        rd(pmcc_pkg::IDX_POWER_MODE, 8'h00);
        rd(pmcc_pkg::IDX_CLOCK_SETUP, 8'h23);
        rd(pmcc_pkg::IDX_AUX_TWO, 8'h06);
        d = 8'($urandom()) & 8'h8c;
        wr(pmcc_pkg::IDX_POWER_MODE, d);
        bus(1'b0, pmcc_pkg::IDX_POWER_MODE, ~d & 8'h8c, 4'h0);
        rd(pmcc_pkg::IDX_POWER_MODE, d);
        wr(pmcc_pkg::IDX_POWER_MODE, 8'h00);
        wr(8'h55, 8'hff);
        rd(8'h55, 8'h00);
        // Every divider code; a slow adoption would show a wrong period.
        for (int c = 0; c < 4; c++) begin
            wr(pmcc_pkg::IDX_CLOCK_SETUP, 8'h20 | 8'(c));
            repeat (17) @(posedge clk);
            tick_period(p);
            check_port("tick period", 32'(divs[c]), 32'(p));
        end
        // Fast oscillator gating and source selection guards.
        wr(pmcc_pkg::IDX_CLOCK_SETUP, 8'h2b);
        repeat (2) @(posedge clk);
        check_port("fast_osc", 32'h0, 32'(gates.fast_osc));
        wr(pmcc_pkg::IDX_CLOCK_SETUP, 8'h2f);
        rd(pmcc_pkg::IDX_CLOCK_SETUP, 8'h2b);
        wr(pmcc_pkg::IDX_CLOCK_SETUP, 8'h23);
        repeat (16) @(posedge clk);
        wr(pmcc_pkg::IDX_CLOCK_SETUP, 8'h27);
        repeat (2) @(posedge clk);
        check_port("source", 32'h1, 32'(sysclk_source_sel));
        check_port("fast_osc", 32'h1, 32'(gates.fast_osc));
        wr(pmcc_pkg::IDX_CLOCK_SETUP, 8'h2f);
        rd(pmcc_pkg::IDX_CLOCK_SETUP, 8'h27);
        wr(pmcc_pkg::IDX_CLOCK_SETUP, 8'h23);
        // Idle with and without peripheral gating, woken by an interrupt.
        for (int g = 0; g < 2; g++) begin
            wr(pmcc_pkg::IDX_CLOCK_SETUP, 8'h23 | 8'(g << 4));
            wr(pmcc_pkg::IDX_POWER_MODE, 8'h01);
            repeat (2) @(posedge clk);
            check_port("mode", 32'(pmcc_pkg::MODE_NAP), 32'(mode));
            check_port("cpu", 32'h0, 32'(gates.cpu));
            check_port("periph", 32'(g == 0), 32'(gates.periph));
            check_port("slow_osc", 32'h1, 32'(gates.slow_osc));
            irq_pending <= 1'b1;
            repeat (3) @(posedge clk);
            check_port("mode", 32'(pmcc_pkg::MODE_RUN), 32'(mode));
            check_port("cpu", 32'h1, 32'(gates.cpu));
            irq_pending <= 1'b0;
            rd(pmcc_pkg::IDX_POWER_MODE, 8'h00);
        end
        // Halt ignores a plain interrupt but wakes on timer3.
        wr(pmcc_pkg::IDX_CLOCK_SETUP, 8'h03);
        tmr3_enable <= 1'b1;
        wr(pmcc_pkg::IDX_POWER_MODE, 8'h02);
        irq_pending <= 1'b1;
        repeat (3) @(posedge clk);
        check_port("mode", 32'(pmcc_pkg::MODE_HALT), 32'(mode));
        check_port("cpu", 32'h0, 32'(gates.cpu));
        check_port("tmr3", 32'h1, 32'(gates.tmr3));
        check_port("fast_osc", 32'h0, 32'(gates.fast_osc));
        irq_pending <= 1'b0;
        tmr3_irq <= 1'b1;
        repeat (3) @(posedge clk);
        check_port("mode", 32'(pmcc_pkg::MODE_RUN), 32'(mode));
        tmr3_irq <= 1'b0;
        rd(pmcc_pkg::IDX_POWER_MODE, 8'h00);
        // Stop wakes only on pins; a low enabled line then blocks entry.
        ln = $urandom_range(2, 0);
        wr(pmcc_pkg::IDX_CLOCK_SETUP, 8'h23);
        wr(pmcc_pkg::IDX_AUX_TWO, 8'hc6);
        wr(pmcc_pkg::IDX_WAKE_CTRL, 8'(1 << ln));
        rd(pmcc_pkg::IDX_WAKE_CTRL, 8'(1 << ln));
        for (int w = 0; w < 2; w++) begin
            wr(pmcc_pkg::IDX_POWER_MODE, 8'h02);
            tmr3_irq <= 1'b1;
            irq_pending <= 1'b1;
            repeat (3) @(posedge clk);
            check_port("mode", 32'(pmcc_pkg::MODE_STOP), 32'(mode));
            check_port("tmr3", 32'h0, 32'(gates.tmr3));
            check_port("wdt", 32'h1, 32'(gates.wdt));
            tmr3_irq <= 1'b0;
            irq_pending <= 1'b0;
            if (w == 0) begin
                ext_line_pin[ln] <= 1'b0;
            end else begin
                port_wake <= 1'b1;
            end
            repeat (3) @(posedge clk);
            check_port("mode", 32'(pmcc_pkg::MODE_RUN), 32'(mode));
            check_port("cpu", 32'h1, 32'(gates.cpu));
            port_wake <= 1'b0;
            if (w == 0) begin
                wr(pmcc_pkg::IDX_POWER_MODE, 8'h02);
                repeat (3) @(posedge clk);
                check_port("mode", 32'(pmcc_pkg::MODE_RUN), 32'(mode));
                rd(pmcc_pkg::IDX_POWER_MODE, 8'h00);
                ext_line_pin[ln] <= 1'b1;
            end
        end
        repeat (4) @(posedge clk);
        if (exp_q.size() != 0) begin
            num_errors++;
            $display("unexpected reads left: expected 0, seen %0d",
                     exp_q.size());
        end
        stop_test();
    end

endmodule // power_mode_clock_ctrl_tb_top
